//--- core/apc_defines.svh
`ifndef APC_DEFINES_SVH
`define APC_DEFINES_SVH

// Clock period of the host logic.
`define APC_CLK_NS        40
// Width of the result bus.
`define APC_DATA_W        8
// Low time of the write strobe (host choice).
`define APC_WR_LOW_CYC    2
// Least write rise to read fall in write-read mode.
`define APC_WR_RD_NS      400
`define APC_WR_RD_CYC     ((`APC_WR_RD_NS + `APC_CLK_NS - 1) / `APC_CLK_NS)
// Longest read-only conversion plus access margin.
`define APC_RO_CONV_NS    2550
`define APC_RO_CONV_CYC   (`APC_RO_CONV_NS / `APC_CLK_NS)
// Longest write rise to done fall.
`define APC_WR_DONE_NS    1300
`define APC_WR_DONE_CYC   (`APC_WR_DONE_NS / `APC_CLK_NS)
// Longest read fall to done fall in write-read mode.
`define APC_RD_DONE_NS    290
`define APC_RD_DONE_CYC   (`APC_RD_DONE_NS / `APC_CLK_NS)
// Least done fall to valid data.
`define APC_SETTLE_NS     50
`define APC_SETTLE_CYC    ((`APC_SETTLE_NS + `APC_CLK_NS - 1) / `APC_CLK_NS)
// Least gap between two conversion cycles.
`define APC_GAP_NS        500
`define APC_GAP_CYC       ((`APC_GAP_NS + `APC_CLK_NS - 1) / `APC_CLK_NS)
// Width of the cycle counter.
`define APC_CNT_W         7

`endif

//--- core/apc_pkg.sv
`include "apc_defines.svh"

package apc_pkg;

  typedef logic [`APC_CNT_W-1:0]  apc_cnt_t;
  typedef logic [`APC_DATA_W-1:0] apc_data_t;

  typedef enum logic [2:0] {
    APC_IDLE,
    APC_WR_LOW,
    APC_WR_WAIT,
    APC_DONE_WAIT,
    APC_SETTLE,
    APC_GAP
  } apc_state_e;

  // Pins driven toward the converter.
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_out;
    logic wr_oe;
    logic mode;
  } apc_pins_s;

  typedef struct packed {
    apc_state_e state;
    apc_cnt_t   cnt;
    apc_pins_s  pins;
    logic       alone;
    apc_data_t  result;
    logic       valid;
    logic       busy;
    logic       timeout;
    logic       dev_busy;
  } apc_st_s;

endpackage : apc_pkg

//--- core/apc_host.sv
// Operation
// - Host raises read; device releases done, data.
// - Host starts write-read with select and write low; read-only starts with select and read low.
// - Host waits 0.4 us write rise to read, except in standalone mode, where read is low from the start.
// - Host waits 500 ns between conversions.
`include "apc_defines.svh"

module apc_host
  import apc_pkg::*;
(
  // Clock and reset.
  input  wire logic      clock,
  input  wire logic      rst_n,
  // User request side.
  input  wire logic      start,
  input  wire logic      write_read,
  input  wire logic      standalone,
  output apc_data_t      result,
  output logic           result_valid,
  output logic           busy,
  output logic           timeout,
  output logic           dev_busy,
  // Converter pins.
  output logic           cs_n,
  output logic           rd_n,
  output logic           wr_rdy_out,
  output logic           wr_rdy_oe,
  input  wire logic      wr_rdy_in,
  output logic           mode,
  input  wire logic      done_n,
  input  wire apc_data_t result_bus
);

  apc_st_s st_reg;
  apc_st_s st_next;

  always_comb begin
    st_next         = st_reg;
    st_next.valid   = 1'b0;
    st_next.timeout = 1'b0;
    // ready low while selected in read-only mode means busy.
    st_next.dev_busy = !st_reg.pins.mode && !st_reg.pins.cs_n && !wr_rdy_in;
    unique case (st_reg.state)
      APC_IDLE: begin
        if (start) begin
          st_next.busy        = 1'b1;
          st_next.pins.cs_n   = 1'b0;
          st_next.pins.mode   = write_read;
          st_next.alone       = write_read && standalone;
          st_next.cnt         = '0;
          if (write_read) begin
            st_next.pins.wr_out = 1'b0;
            st_next.pins.wr_oe  = 1'b1;
            st_next.pins.rd_n   = !standalone;
            st_next.state       = APC_WR_LOW;
          end else begin
            // read fall starts a read-only conversion.
            st_next.pins.rd_n   = 1'b0;
            st_next.state       = APC_DONE_WAIT;
          end
        end
      end
      APC_WR_LOW: begin
        st_next.cnt = st_reg.cnt + 1'b1;
        if (st_reg.cnt == `APC_CNT_W'(`APC_WR_LOW_CYC - 1)) begin
          // conversion runs from the write rise.
          st_next.pins.wr_out = 1'b1;
          st_next.cnt         = '0;
          st_next.state       = st_reg.alone ? APC_DONE_WAIT : APC_WR_WAIT;
        end
      end
      APC_WR_WAIT: begin
        st_next.cnt = st_reg.cnt + 1'b1;
        // read only after the write-to-read delay.
        if (st_reg.cnt == `APC_CNT_W'(`APC_WR_RD_CYC - 1)) begin
          st_next.pins.rd_n = 1'b0;
          st_next.cnt       = '0;
          st_next.state     = APC_DONE_WAIT;
        end
      end
      APC_DONE_WAIT: begin
        st_next.cnt = st_reg.cnt + 1'b1;
        if (!done_n) begin
          st_next.cnt   = '0;
          st_next.state = APC_SETTLE;
        end else if ((!st_reg.pins.mode && st_reg.cnt == `APC_CNT_W'(`APC_RO_CONV_CYC)) ||
                     (st_reg.alone && st_reg.cnt == `APC_CNT_W'(`APC_WR_DONE_CYC)) ||
                     (st_reg.pins.mode && !st_reg.alone &&
                      st_reg.cnt == `APC_CNT_W'(`APC_RD_DONE_CYC))) begin
          // A converter that never answers must not hang the host.
          st_next.timeout     = 1'b1;
          st_next.pins.rd_n   = 1'b1;
          st_next.pins.cs_n   = 1'b1;
          st_next.pins.wr_oe  = 1'b0;
          st_next.cnt         = '0;
          st_next.state       = APC_GAP;
        end
      end
      APC_SETTLE: begin
        st_next.cnt = st_reg.cnt + 1'b1;
        // sample only after the data settle time.
        if (st_reg.cnt == `APC_CNT_W'(`APC_SETTLE_CYC - 1)) begin
          st_next.result      = result_bus;
          st_next.valid       = 1'b1;
          // raise read once the data is taken.
          st_next.pins.rd_n   = 1'b1;
          // deselect and release the shared pin together.
          st_next.pins.cs_n   = 1'b1;
          st_next.pins.wr_oe  = 1'b0;
          st_next.cnt         = '0;
          st_next.state       = APC_GAP;
        end
      end
      APC_GAP: begin
        st_next.cnt = st_reg.cnt + 1'b1;
        if (st_reg.cnt == `APC_CNT_W'(`APC_GAP_CYC - 1)) begin
          st_next.busy  = 1'b0;
          st_next.cnt   = '0;
          st_next.state = APC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg             <= '0;
      st_reg.state       <= APC_IDLE;
      st_reg.pins.cs_n   <= 1'b1;
      st_reg.pins.rd_n   <= 1'b1;
      st_reg.pins.wr_out <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign result       = st_reg.result;
  assign result_valid = st_reg.valid;
  assign busy         = st_reg.busy;
  assign timeout      = st_reg.timeout;
  assign dev_busy     = st_reg.dev_busy;
  assign cs_n         = st_reg.pins.cs_n;
  assign rd_n         = st_reg.pins.rd_n;
  assign wr_rdy_out   = st_reg.pins.wr_out;
  assign wr_rdy_oe    = st_reg.pins.wr_oe;
  assign mode         = st_reg.pins.mode;

  // Helper counters: cycles since the write rose and since deselect.
  apc_cnt_t since_wr;
  apc_cnt_t since_cs;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      since_wr <= '1;
      since_cs <= '1;
    end else begin
      since_wr <= (!wr_rdy_out) ? '0 : (since_wr == '1 ? since_wr : since_wr + 1'b1);
      since_cs <= (!cs_n) ? '0 : (since_cs == '1 ? since_cs : since_cs + 1'b1);
    end
  end

  a_wr_rd_delay: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(rd_n) && mode && wr_rdy_oe |-> since_wr >= `APC_CNT_W'(`APC_WR_RD_CYC))
    else $error("read fell too soon after write rose");

  a_gap_time: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(cs_n) |-> $past(since_cs) >= `APC_CNT_W'(`APC_GAP_CYC))
    else $error("next conversion started too soon");

  a_start_write: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(cs_n) && mode |-> !wr_rdy_out && wr_rdy_oe)
    else $error("select and write not low together");

  a_read_release: assert property (@(posedge clock) disable iff (!rst_n)
    result_valid |-> rd_n && cs_n && $past(!rd_n))
    else $error("read not raised with data capture");

  a_desel_float: assert property (@(posedge clock) disable iff (!rst_n)
    cs_n |-> !wr_rdy_oe && rd_n)
    else $error("strobes active while deselected");

  a_ro_no_drive: assert property (@(posedge clock) disable iff (!rst_n)
    !mode |-> !wr_rdy_oe)
    else $error("ready pin driven in read-only mode");

  a_settle_data: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(done_n) && !cs_n |-> !result_valid [*2])
    else $error("data taken before settle time");

  a_start_ro: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(cs_n) && !mode |-> !rd_n)
    else $error("read-only cycle without read fall");

  a_timeout_free: assert property (@(posedge clock) disable iff (!rst_n)
    timeout |-> cs_n && rd_n && !wr_rdy_oe)
    else $error("pins not released after timeout");

  a_wr_low_width: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(wr_rdy_out) |-> !wr_rdy_out [*2])
    else $error("write strobe low too short");

endmodule : apc_host

//--- verification/apc_dev_model.sv
module apc_dev_model
  import apc_pkg::*;
(
  // Host pins.
  input  wire logic       clock,
  input  wire logic       cs_n,
  input  wire logic       rd_n,
  input  wire logic       wr_pin,
  input  wire logic       mode,
  // Scenario controls.
  input  wire apc_data_t  sample,
  input  wire logic [7:0] conv_cyc,
  // Device outputs.
  output logic            done_n,
  output logic            rdy_oe,
  output apc_data_t       bus
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       rd_q = 1'b1;
  logic       wr_q = 1'b1;
  logic       conv = 1'b0;
  logic       drv  = 1'b0;
  logic [7:0] cnt  = 8'h00;
  logic [7:0] rcnt = 8'h00;
  apc_data_t  lat  = 8'h00;
  initial done_n = 1'b1;
  initial rdy_oe = 1'b0;
  // released bus
  // A floating bus shows the inverse of the last value, so stale data never matches.
  assign bus = drv ? lat : ~lat;
  always @(posedge clock) begin
    rd_q <= rd_n;
    wr_q <= wr_pin;
    rcnt <= rd_n ? 8'h00 : rcnt + 8'h01;
    if (cs_n) begin
      conv <= 1'b0;
      drv <= 1'b0;
      done_n <= 1'b1;
      rdy_oe <= 1'b0;
    end else begin
      if (!mode && rd_q && !rd_n) begin
        conv <= 1'b1;
        cnt <= 8'h00;
        rdy_oe <= 1'b1;
      end
      if (mode && !wr_q && wr_pin) begin
        conv <= 1'b1;
        cnt <= 8'h00;
        rcnt <= 8'h00;
        done_n <= 1'b1;
      end
      if (conv) cnt <= cnt + 8'h01;
      // conversion end; a count of 8'hff models a dead device.
      if (conv_cyc != 8'hff && conv && (cnt == conv_cyc || (mode && rcnt == 8'h04))) begin
        conv <= 1'b0;
        done_n <= 1'b0;
        rdy_oe <= 1'b0;
        lat <= {sample[7:4], sample[3:0]};
      end
      if (!done_n && !rd_n) drv <= 1'b1;
      if (!rd_q && rd_n) begin
        done_n <= 1'b1;
        drv <= 1'b0;
      end
    end
  end
endmodule : apc_dev_model

//--- verification/adc_parallel_bus_conversion_control_tb.sv
`include "apc_defines.svh"

module adc_parallel_bus_conversion_control_tb
  import apc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clock = 1'b0;
  logic       rst_n = 1'b0;
  logic       start = 1'b0;
  logic       write_read = 1'b0;
  logic       standalone = 1'b0;
  logic [7:0] conv_cyc = 8'h04;
  apc_data_t  sample = 8'h00;
  apc_data_t  result, result_bus;
  logic       result_valid, busy, timeout, dev_busy, cs_n, rd_n;
  logic       wr_rdy_out, wr_rdy_oe, mode, done_n, rdy_oe, wr_pin;
  int         bad_count = 0;
  int         compares = 0;
  // The shared pin has a pull-up; the device only ever pulls it low.
  assign wr_pin = wr_rdy_oe ? wr_rdy_out : !rdy_oe;
  always #20 clock = ~clock;
  apc_host dut_u (.clock(clock), .rst_n(rst_n), .start(start), .write_read(write_read),
    .standalone(standalone), .result(result), .result_valid(result_valid), .busy(busy),
    .timeout(timeout), .dev_busy(dev_busy), .cs_n(cs_n), .rd_n(rd_n),
    .wr_rdy_out(wr_rdy_out), .wr_rdy_oe(wr_rdy_oe), .wr_rdy_in(wr_pin), .mode(mode),
    .done_n(done_n), .result_bus(result_bus));
  apc_dev_model dev_u (.clock(clock), .cs_n(cs_n), .rd_n(rd_n), .wr_pin(wr_pin),
    .mode(mode), .sample(sample), .conv_cyc(conv_cyc), .done_n(done_n),
    .rdy_oe(rdy_oe), .bus(result_bus));
  task automatic stop_test;
    $display("mismatches %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk1
  task automatic chk8(input apc_data_t got, input apc_data_t exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk_cyc(input int got, input int exp);
    compares++;
    if (got != exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_cyc
  // One request end to end; poke retries start while busy, which must be ignored.
  task automatic run(input logic wr, sa, poke, exp_to, input apc_data_t smp,
                     input logic [7:0] cyc);
    int n;
    int vals;
    logic seen;
    logic tseen;
    int tn;
    int cn;
    int exp_n;
    n = 0;
    vals = 0;
    tn = 0;
    cn = 0;
    exp_n = 0;
    seen = 1'b0;
    tseen = 1'b0;
    @(negedge clock);
    write_read = wr;
    standalone = sa;
    sample = smp;
    conv_cyc = cyc;
    start = 1'b1;
    @(negedge clock);
    start = 1'b0;
    chk1(busy, 1'b1);
    chk1(mode, wr);
    chk1(wr_rdy_oe, wr);
    while (busy && n < 300) begin
      @(negedge clock);
      n++;
      start = poke && n == 5;
      seen |= dev_busy;
      tseen |= timeout;
      if (timeout) tn = n;
      if (cs_n && cn == 0) cn = n;
      if (result_valid) begin
        vals++;
        chk8(result, smp);
      end
    end
    chk1(busy, 1'b0);
    chk1(tseen, exp_to);
    chk1(vals == (exp_to ? 0 : 1), 1'b1);
    chk1(seen, !wr);
    chk1(cs_n, 1'b1);
    chk1(rd_n, 1'b1);
    chk1(wr_rdy_oe, 1'b0);
    chk_cyc(n - cn, `APC_GAP_CYC);
    if (exp_to) begin
      if (!wr) exp_n = `APC_RO_CONV_CYC + 1;
      else if (sa) exp_n = `APC_WR_LOW_CYC + `APC_WR_DONE_CYC + 1;
      else exp_n = `APC_WR_LOW_CYC + `APC_WR_RD_CYC + `APC_RD_DONE_CYC + 1;
      chk_cyc(tn, exp_n);
    end
  endtask : run
  task automatic t_read_only;
    run(1'b0, 1'b0, 1'b0, 1'b0, 8'h5a, 8'd40);
  endtask : t_read_only
  task automatic t_bounds;
    run(1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 8'd2);
    run(1'b1, 1'b0, 1'b0, 1'b0, 8'hff, 8'd8);
  endtask : t_bounds
  task automatic t_write_read;
    run(1'b1, 1'b0, 1'b0, 1'b0, 8'ha5, 8'd8);
  endtask : t_write_read
  task automatic t_early_read;
    run(1'b1, 1'b0, 1'b0, 1'b0, 8'h3c, 8'd60);
  endtask : t_early_read
  task automatic t_standalone;
    run(1'b1, 1'b1, 1'b0, 1'b0, 8'h96, 8'd10);
    run(1'b1, 1'b1, 1'b0, 1'b0, 8'h69, 8'd3);
  endtask : t_standalone
  task automatic t_timeout;
    run(1'b0, 1'b0, 1'b0, 1'b1, 8'h11, 8'hff);
    run(1'b1, 1'b0, 1'b0, 1'b1, 8'h22, 8'hff);
    run(1'b1, 1'b1, 1'b0, 1'b1, 8'h33, 8'hff);
  endtask : t_timeout
  task automatic t_ignore;
    run(1'b0, 1'b0, 1'b1, 1'b0, 8'h77, 8'd10);
  endtask : t_ignore
  initial begin
    #(40 * 4000);
    bad_count++;
    stop_test;
  end
  initial begin
    repeat (20) @(negedge clock);
    rst_n = 1'b1;
    t_read_only;
    t_bounds;
    t_write_read;
    t_early_read;
    t_standalone;
    t_timeout;
    t_ignore;
    stop_test;
  end
endmodule : adc_parallel_bus_conversion_control_tb
